// file: prq_pkg.sv
/*
 pgev_pkg: shared constants for the page request event and group response block.
 assumes: a 25 MHz single clock domain; register offsets are byte addresses on the plain port.
*/
package pgev_pkg;
   // ==================================================
   // widths
   localparam int DESC_W = 256;
   localparam int IDX_W = 4;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int RID_W = 16;
   localparam int PASID_W = 20;
   localparam int GRP_W = 9;
   localparam int RC_W = 4;
   localparam int TYPE_W = 7;

   // ==================================================
   // register offsets
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_EVCTL = 8'h04;
   localparam logic [ADDR_W-1:0] ADDR_HEAD = 8'h08;
   localparam logic [ADDR_W-1:0] ADDR_TAIL = 8'h0c;
   localparam logic [ADDR_W-1:0] ADDR_IQCFG = 8'h10;
   localparam logic [ADDR_W-1:0] ADDR_EVDATA = 8'h14;
   localparam logic [ADDR_W-1:0] ADDR_EVADDR = 8'h18;

   // ==================================================
   // field positions
   localparam int ST_PEND_BIT = 0;
   localparam int ST_OVF_BIT = 1;
   localparam int EC_MASK_BIT = 31;
   localparam int EC_IP_BIT = 30;
   localparam int IQCFG_WIDE_BIT = 0;
   localparam int DSC_PASID_ON_BIT = 4;
   localparam int DSC_RC_LSB = 12;
   localparam int DSC_RID_LSB = 16;
   localparam int DSC_PASID_LSB = 32;
   localparam int DSC_GRP_LSB = 64;

   // ==================================================
   // values after reset
   localparam logic EC_MASK_RST = 1'b1;
   localparam logic IQCFG_WIDE_RST = 1'b1;
   localparam logic [DATA_W-1:0] EVDATA_RST = 32'h0000_0000;
   localparam logic [DATA_W-1:0] EVADDR_RST = 32'h0000_0000;
   localparam logic [IDX_W-1:0] IDX_RST = 4'h0;

   // ==================================================
   // encodings
   localparam logic [TYPE_W-1:0] TYPE_GRP_RESP = 7'h09;
   localparam logic [RC_W-1:0] RC_SUCCESS = 4'h0;
   localparam logic [RC_W-1:0] RC_INVALID = 4'h1;
   localparam logic [RC_W-1:0] RC_FAILURE = 4'hf;

   typedef enum logic [1:0] {
      WR_IDLE = 2'b00,
      WR_BUSY = 2'b01
   } pgev_wr_state_t;
endpackage

// file: prq_queue.sv
/*
 pgev_queue: writes accepted page request descriptors into the fault request queue, one at a time.
 assumes: wr_visible comes from the memory path on ref_clk and is high once the write is software visible.
*/
`timescale 1ns/1ns
module pgev_queue import pgev_pkg::*; (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic req_valid,
   input wire logic [DESC_W-1:0] req_desc,
   input wire logic [IDX_W-1:0] head_idx,
   input wire logic wr_visible,
   output logic req_ready_q,
   output logic wr_valid_q,
   output logic [IDX_W-1:0] wr_index_q,
   output logic [DESC_W-1:0] wr_data_q,
   output logic [IDX_W-1:0] tail_q,
   output logic delivered_q,
   output logic overflow_q
);
   // ==================================================
   // pointers
   function automatic logic [IDX_W-1:0] next_idx(input logic [IDX_W-1:0] i);
      next_idx = i + 4'h1;
   endfunction

   pgev_wr_state_t state_q;
   wire logic take = req_valid && req_ready_q && (state_q == WR_IDLE);
   wire logic full = (next_idx(tail_q) == head_idx);

   // ==================================================
   // write sequencer
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         state_q <= WR_IDLE;
         req_ready_q <= 1'b0;
         wr_valid_q <= 1'b0;
         wr_index_q <= IDX_RST;
         wr_data_q <= '0;
         tail_q <= IDX_RST;
         delivered_q <= 1'b0;
         overflow_q <= 1'b0;
      end else begin
         delivered_q <= 1'b0;
         overflow_q <= 1'b0;
         case (state_q)
            WR_IDLE: begin
               req_ready_q <= 1'b1;
               if (take && full) begin
                  overflow_q <= 1'b1;
               end else if (take) begin
                  wr_valid_q <= 1'b1;
                  wr_index_q <= tail_q;
                  wr_data_q <= req_desc;
                  req_ready_q <= 1'b0;
                  state_q <= WR_BUSY;
               end
            end
            WR_BUSY: begin
               // tail moves only once the entry is visible
               if (wr_visible) begin
                  wr_valid_q <= 1'b0;
                  tail_q <= next_idx(tail_q);
                  delivered_q <= 1'b1;
                  req_ready_q <= 1'b1;
                  state_q <= WR_IDLE;
               end
            end
            default: begin
               state_q <= WR_IDLE;
            end
         endcase
      end
   end

   AST_FULL_DROPS: assert property (@(posedge ref_clk) disable iff (!resetn)
      take && full |=> overflow_q && !wr_valid_q)
      else $error("request taken into a full queue");
   AST_TAIL_AFTER_VIS: assert property (@(posedge ref_clk) disable iff (!resetn)
      wr_valid_q && !wr_visible |=> $stable(tail_q))
      else $error("tail moved before the write was visible");
endmodule

// file: prq_resp_dec.sv
/*
 pgev_resp_dec: decodes group response descriptors from the invalidation queue into response messages when wide_sel is set, else flags desc_err_q.
 assumes: one descriptor per iq_valid cycle; other descriptor types are handled elsewhere and ignored here.
*/
`timescale 1ns/1ns
module pgev_resp_dec import pgev_pkg::*; (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic iq_valid,
   input wire logic [DESC_W-1:0] iq_desc,
   input wire logic wide_sel,
   output logic resp_valid_q,
   output logic [RID_W-1:0] resp_rid_q,
   output logic resp_pasid_on_q,
   output logic [PASID_W-1:0] resp_pasid_q,
   output logic [GRP_W-1:0] resp_grp_q,
   output logic [RC_W-1:0] resp_code_q,
   output logic desc_err_q
);
   // ==================================================
   // decode
   wire logic [TYPE_W-1:0] dsc_type = {iq_desc[11:9], iq_desc[3:0]};
   wire logic is_grp = iq_valid && (dsc_type == TYPE_GRP_RESP);
   wire logic pasid_on = iq_desc[DSC_PASID_ON_BIT];
   // pasid is zeroed when absent so stale bits never leak onto the link
   wire logic [PASID_W-1:0] pasid = pasid_on ? iq_desc[DSC_PASID_LSB +: PASID_W] : 20'h00000;

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         resp_valid_q <= 1'b0;
         resp_rid_q <= 16'h0000;
         resp_pasid_on_q <= 1'b0;
         resp_pasid_q <= 20'h00000;
         resp_grp_q <= 9'h000;
         resp_code_q <= RC_SUCCESS;
         desc_err_q <= 1'b0;
      end else begin
         resp_valid_q <= is_grp && wide_sel;
         desc_err_q <= is_grp && !wide_sel;
         if (is_grp && wide_sel) begin
            resp_rid_q <= iq_desc[DSC_RID_LSB +: RID_W];
            resp_pasid_on_q <= pasid_on;
            resp_pasid_q <= pasid;
            resp_grp_q <= iq_desc[DSC_GRP_LSB +: GRP_W];
            resp_code_q <= iq_desc[DSC_RC_LSB +: RC_W];
         end
      end
   end

   AST_RESP_SENT: assert property (@(posedge ref_clk) disable iff (!resetn)
      is_grp && wide_sel |=> resp_valid_q && resp_code_q == $past(iq_desc[DSC_RC_LSB +: RC_W]))
      else $error("group response not sent with its code");
   AST_NARROW_ERR: assert property (@(posedge ref_clk) disable iff (!resetn)
      is_grp && !wide_sel |=> desc_err_q && !resp_valid_q)
      else $error("narrow queue did not flag the wide descriptor");
endmodule

// file: prq_event_resp.sv
/*
 pgev_event_resp: recoverable fault event logic and page group response path of the remapping unit.
 assumes: one ref_clk domain, register master on the same clock, memory path acknowledges
 descriptor visibility with dsc_wr_visible, interrupt fabric takes irq_q as a one-cycle message request.
*/
// Our own choices: strobed register access and the register offsets.
`timescale 1ns/1ns
module pgev_event_resp import pgev_pkg::*; (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [DATA_W-1:0] reg_rdata_q,
   input wire logic req_valid,
   input wire logic [DESC_W-1:0] req_desc,
   output logic req_ready_q,
   output logic dsc_wr_valid_q,
   output logic [IDX_W-1:0] dsc_wr_index_q,
   output logic [DESC_W-1:0] dsc_wr_data_q,
   input wire logic dsc_wr_visible,
   output logic irq_q,
   output logic [DATA_W-1:0] irq_addr_q,
   output logic [DATA_W-1:0] irq_data_q,
   input wire logic iq_valid,
   input wire logic [DESC_W-1:0] iq_desc,
   output logic resp_valid_q,
   output logic [RID_W-1:0] resp_rid_q,
   output logic resp_pasid_on_q,
   output logic [PASID_W-1:0] resp_pasid_q,
   output logic [GRP_W-1:0] resp_grp_q,
   output logic [RC_W-1:0] resp_code_q,
   output logic desc_err_q
);
   // ==================================================
   // state
   logic pend_q;
   logic pend_d;
   logic ovf_q;
   logic ovf_d;
   logic ip_q;
   logic ip_d;
   logic mask_q;
   logic mask_d;
   logic wide_q;
   logic [IDX_W-1:0] head_q;
   logic [DATA_W-1:0] evdata_q;
   logic [DATA_W-1:0] evaddr_q;
   logic [IDX_W-1:0] tail_w;
   logic delivered_w;
   logic overflow_w;

   // ==================================================
   // request queue writer
   pgev_queue u_queue (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .req_valid(req_valid),
      .req_desc(req_desc),
      .head_idx(head_q),
      .wr_visible(dsc_wr_visible),
      .req_ready_q(req_ready_q),
      .wr_valid_q(dsc_wr_valid_q),
      .wr_index_q(dsc_wr_index_q),
      .wr_data_q(dsc_wr_data_q),
      .tail_q(tail_w),
      .delivered_q(delivered_w),
      .overflow_q(overflow_w)
   );

   // ==================================================
   // group response decoder
   pgev_resp_dec u_resp (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .iq_valid(iq_valid),
      .iq_desc(iq_desc),
      .wide_sel(wide_q),
      .resp_valid_q(resp_valid_q),
      .resp_rid_q(resp_rid_q),
      .resp_pasid_on_q(resp_pasid_on_q),
      .resp_pasid_q(resp_pasid_q),
      .resp_grp_q(resp_grp_q),
      .resp_code_q(resp_code_q),
      .desc_err_q(desc_err_q)
   );

   // ==================================================
   // register decode
   wire logic wr_stat = reg_wr && (reg_addr == ADDR_STATUS);
   wire logic wr_ctl = reg_wr && (reg_addr == ADDR_EVCTL);
   wire logic wr_head = reg_wr && (reg_addr == ADDR_HEAD);
   wire logic wr_iqcfg = reg_wr && (reg_addr == ADDR_IQCFG);
   wire logic wr_evdata = reg_wr && (reg_addr == ADDR_EVDATA);
   wire logic wr_evaddr = reg_wr && (reg_addr == ADDR_EVADDR);
   wire logic clr_pend = wr_stat && reg_wdata[ST_PEND_BIT];
   wire logic clr_ovf = wr_stat && reg_wdata[ST_OVF_BIT];

   // ==================================================
   // status flags, write one to clear; a new set beats a clear in the same cycle
   assign pend_d = (pend_q && !clr_pend) || delivered_w;
   assign ovf_d = (ovf_q && !clr_ovf) || overflow_w;

   // ==================================================
   // event evaluation uses the flags as they stood before this cycle's set
   wire logic evt_src = delivered_w || overflow_w;
   wire logic evt = evt_src && !pend_q && !ovf_q;
   wire logic ip_hold = ip_q || evt;
   // a write still in flight holds the interrupt back so software never
   // sees an event ahead of the descriptor it announces
   wire logic wr_busy = dsc_wr_valid_q;
   assign mask_d = wr_ctl ? reg_wdata[EC_MASK_BIT] : mask_q;
   wire logic fire = ip_hold && !mask_d && !wr_busy;
   wire logic svc_clear = ip_q && wr_stat && !pend_d && !ovf_d;
   assign ip_d = ip_hold && !fire && !svc_clear;

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         pend_q <= 1'b0;
         ovf_q <= 1'b0;
         ip_q <= 1'b0;
         mask_q <= EC_MASK_RST;
      end else begin
         pend_q <= pend_d;
         ovf_q <= ovf_d;
         ip_q <= ip_d;
         mask_q <= mask_d;
      end
   end

   // ==================================================
   // interrupt message: address and data go out exactly as programmed,
   // no remapping lookup sits on this path
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         irq_q <= 1'b0;
         irq_addr_q <= EVADDR_RST;
         irq_data_q <= EVDATA_RST;
      end else begin
         irq_q <= fire;
         if (fire) begin
            irq_addr_q <= evaddr_q;
            irq_data_q <= evdata_q;
         end
      end
   end

   // ==================================================
   // configuration registers
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         head_q <= IDX_RST;
         wide_q <= IQCFG_WIDE_RST;
         evdata_q <= EVDATA_RST;
         evaddr_q <= EVADDR_RST;
      end else begin
         if (wr_head) begin
            head_q <= reg_wdata[IDX_W-1:0];
         end
         if (wr_iqcfg) begin
            wide_q <= reg_wdata[IQCFG_WIDE_BIT];
         end
         if (wr_evdata) begin
            evdata_q <= reg_wdata;
         end
         if (wr_evaddr) begin
            evaddr_q <= reg_wdata;
         end
      end
   end

   // ==================================================
   // read mux; the tail shown is the visible tail, so a completion never
   // reports an entry whose write is not yet visible
   wire logic [DATA_W-1:0] rd_status = {30'h0, ovf_q, pend_q};
   wire logic [DATA_W-1:0] rd_evctl = {mask_q, ip_q, 30'h0};
   wire logic [DATA_W-1:0] rd_head = {28'h000_0000, head_q};
   wire logic [DATA_W-1:0] rd_tail = {28'h000_0000, tail_w};
   wire logic [DATA_W-1:0] rd_iqcfg = {31'h0, wide_q};
   logic [DATA_W-1:0] rd_mux;

   always_comb begin
      case (reg_addr)
         ADDR_STATUS: rd_mux = rd_status;
         ADDR_EVCTL: rd_mux = rd_evctl;
         ADDR_HEAD: rd_mux = rd_head;
         ADDR_TAIL: rd_mux = rd_tail;
         ADDR_IQCFG: rd_mux = rd_iqcfg;
         ADDR_EVDATA: rd_mux = evdata_q;
         ADDR_EVADDR: rd_mux = evaddr_q;
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // the interrupt leaves on the edge that updates the state, so any
   // completion, which stands one cycle later, is already ordered behind it
   wire logic [DATA_W-1:0] rd_d = reg_rd ? rd_mux : 32'h0000_0000;

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         reg_rdata_q <= 32'h0000_0000;
      end else begin
         reg_rdata_q <= rd_d;
      end
   end

   // ==================================================
   // checks
   AST_PEND_SET: assert property (@(posedge ref_clk) disable iff (!resetn)
      delivered_w |=> pend_q)
      else $error("pending flag not set after descriptor write");
   AST_OVF_SET: assert property (@(posedge ref_clk) disable iff (!resetn)
      overflow_w |=> ovf_q)
      else $error("overflow flag not set on full queue");
   AST_SUPPRESS: assert property (@(posedge ref_clk) disable iff (!resetn)
      evt_src && (pend_q || ovf_q) && !ip_q |=> !irq_q && !ip_q)
      else $error("event raised while a flag was already set");
   AST_HOLD_MASKED: assert property (@(posedge ref_clk) disable iff (!resetn)
      evt && mask_q && !wr_ctl |=> ip_q && !irq_q)
      else $error("masked event not held in interrupt pending");
   AST_FIRE_UNMASKED: assert property (@(posedge ref_clk) disable iff (!resetn)
      evt && !mask_q && !wr_ctl |=> irq_q && !ip_q)
      else $error("unmasked event did not fire and clear pending");
   AST_MASKED_QUIET: assert property (@(posedge ref_clk) disable iff (!resetn)
      mask_q && !wr_ctl |=> !irq_q)
      else $error("interrupt issued while masked");
   AST_UNMASK_FIRE: assert property (@(posedge ref_clk) disable iff (!resetn)
      ip_q && mask_q && wr_ctl && !reg_wdata[EC_MASK_BIT] && !wr_busy |=> irq_q && !ip_q ##1 !irq_q)
      else $error("held event not fired on unmask");
   AST_SVC_CLEAR: assert property (@(posedge ref_clk) disable iff (!resetn)
      ip_q && mask_q && wr_stat && !pend_d && !ovf_d && !wr_ctl |=> !ip_q && !irq_q)
      else $error("pending not dropped when flags serviced");
   AST_IRQ_VISIBLE: assert property (@(posedge ref_clk) disable iff (!resetn)
      irq_q |-> !$past(dsc_wr_valid_q))
      else $error("interrupt issued with a descriptor write in flight");
   AST_IRQ_PROGRAMMED: assert property (@(posedge ref_clk) disable iff (!resetn)
      fire |=> irq_addr_q == $past(evaddr_q) && irq_data_q == $past(evdata_q))
      else $error("interrupt message not as programmed");
   AST_READ_TIMING: assert property (@(posedge ref_clk) disable iff (!resetn)
      reg_rd && reg_addr == ADDR_TAIL |=> reg_rdata_q == {28'h000_0000, $past(tail_w)})
      else $error("tail read returned wrong value");
endmodule

// file: prq_ep_model.sv
/*
 pgev_ep_model: endpoint that offers page requests, plus the memory path that reports write visibility.
 assumes: ref_clk domain; the bench pulses offer with a descriptor and picks vis_delay.
*/
`timescale 1ns/1ns
module pgev_ep_model import pgev_pkg::*; (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic offer,
   input wire logic [DESC_W-1:0] desc,
   input wire logic [3:0] vis_delay,
   input wire logic req_ready_q,
   input wire logic dsc_wr_valid_q,
   output logic req_valid,
   output logic [DESC_W-1:0] req_desc,
   output logic dsc_wr_visible
);
   logic [3:0] wait_q;
   logic done_q;
   // ==================================================
   // offer held until taken; released data is scrambled so stale values never pass
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         req_valid <= 1'b0;
         req_desc <= '0;
      end else if (offer) begin
         req_valid <= 1'b1;
         req_desc <= desc;
      end else if (req_valid && req_ready_q) begin
         req_valid <= 1'b0;
         req_desc <= ~req_desc;
      end
   end
   // ==================================================
   // one visibility pulse per write, prompt or slow
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         wait_q <= 4'h0;
         done_q <= 1'b0;
         dsc_wr_visible <= 1'b0;
      end else begin
         dsc_wr_visible <= 1'b0;
         if (!dsc_wr_valid_q) begin
            wait_q <= 4'h0;
            done_q <= 1'b0;
         end else if (!done_q && wait_q == vis_delay) begin
            dsc_wr_visible <= 1'b1;
            done_q <= 1'b1;
         end else if (!done_q) begin
            wait_q <= wait_q + 4'h1;
         end
      end
   end
endmodule

// file: tb.sv
/*
 tb: self-checking bench for pgev_event_resp against a behavioural flag, interrupt and response model.
 assumes: pgev_pkg and pgev_ep_model compiled first; read and send checks sample 1 ns after the edge, the monitor samples at the edge.
*/
`timescale 1ns/1ns
module tb import pgev_pkg::*; ;
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   logic [ADDR_W-1:0] reg_addr = '0;
   logic [DATA_W-1:0] reg_wdata = '0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic offer = 1'b0;
   logic [DESC_W-1:0] desc = '0;
   logic [3:0] vis_delay = 4'h0;
   logic iq_valid = 1'b0;
   logic [DESC_W-1:0] iq_desc = '0;
   logic [DATA_W-1:0] reg_rdata_q, irq_addr_q, irq_data_q, ev_addr, ev_data;
   logic req_valid, req_ready_q, dsc_wr_valid_q, dsc_wr_visible, irq_q, resp_valid_q, resp_pasid_on_q, desc_err_q;
   logic [DESC_W-1:0] req_desc, dsc_wr_data_q;
   logic [IDX_W-1:0] dsc_wr_index_q, tail_m, h;
   logic [RID_W-1:0] resp_rid_q;
   logic [PASID_W-1:0] resp_pasid_q;
   logic [GRP_W-1:0] resp_grp_q;
   logic [RC_W-1:0] resp_code_q;
   logic pend_m = 1'b0;
   logic ovf_m = 1'b0;
   logic ip_m = 1'b0;
   logic mask_m = EC_MASK_RST;
   logic [49:0] exp_q[$];
   integer err_count = 0, tests_run = 0, seed = 22, irq_cnt = 0, exp_irq = 0, resp_cnt = 0, derr_cnt = 0;
   integer derr_exp = 0;
   pgev_event_resp dut_u (.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .req_valid(req_valid), .req_desc(req_desc),
      .req_ready_q(req_ready_q), .dsc_wr_valid_q(dsc_wr_valid_q), .dsc_wr_index_q(dsc_wr_index_q),
      .dsc_wr_data_q(dsc_wr_data_q), .dsc_wr_visible(dsc_wr_visible), .irq_q(irq_q), .irq_addr_q(irq_addr_q),
      .irq_data_q(irq_data_q), .iq_valid(iq_valid), .iq_desc(iq_desc), .resp_valid_q(resp_valid_q),
      .resp_rid_q(resp_rid_q), .resp_pasid_on_q(resp_pasid_on_q), .resp_pasid_q(resp_pasid_q),
      .resp_grp_q(resp_grp_q), .resp_code_q(resp_code_q), .desc_err_q(desc_err_q));
   pgev_ep_model ep_u (.ref_clk(ref_clk), .resetn(resetn), .offer(offer), .desc(desc), .vis_delay(vis_delay),
      .req_ready_q(req_ready_q), .dsc_wr_valid_q(dsc_wr_valid_q), .req_valid(req_valid), .req_desc(req_desc),
      .dsc_wr_visible(dsc_wr_visible));
   // ==================================================
   // checking and closing
   task automatic chk(input logic [255:0] seen, input logic [255:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test;
      $display("mismatches %0d of %0d checks", err_count, tests_run);
      if (err_count == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // ==================================================
   // register port; the flag model follows every write
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      if (a == ADDR_STATUS) begin
         pend_m = pend_m & ~d[ST_PEND_BIT];
         ovf_m = ovf_m & ~d[ST_OVF_BIT];
         ip_m = ip_m & (pend_m | ovf_m);
      end
      if (a == ADDR_EVCTL) begin
         mask_m = d[EC_MASK_BIT];
         if (ip_m && !mask_m) begin
            exp_irq++;
            ip_m = 1'b0;
         end
      end
   endtask
   task automatic rchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata_q, e);
   endtask
   task automatic regs_chk;
      rchk(ADDR_STATUS, {30'h0, ovf_m, pend_m});
      chk(irq_cnt, exp_irq);
      rchk(ADDR_EVCTL, {mask_m, ip_m, 30'h0});
      rchk(ADDR_TAIL, {28'h0, tail_m});
   endtask
   task automatic bail;
      err_count++;
      end_of_test();
   endtask
   // ==================================================
   // one page request; exp_wr low means the queue is full
   task automatic send(input logic exp_wr);
      logic [255:0] d;
      int n;
      for (n = 0; n < 8; n++) d[n*32+:32] = $random(seed);
      @(posedge ref_clk);
      offer <= 1'b1;
      desc <= d;
      @(posedge ref_clk);
      offer <= 1'b0;
      #1;
      for (n = 0; req_valid !== 1'b0; n++) begin
         if (n > 40) bail();
         @(posedge ref_clk);
         #1;
      end
      chk(dsc_wr_valid_q, exp_wr);
      chk(req_ready_q, !exp_wr);
      if (exp_wr) begin
         chk(dsc_wr_data_q, d);
         chk(dsc_wr_index_q, tail_m);
         rchk(ADDR_TAIL, {28'h0, tail_m});
         tail_m++;
      end
      for (n = 0; dsc_wr_valid_q !== 1'b0; n++) begin
         if (n > 40) bail();
         @(posedge ref_clk);
         #1;
      end
      chk(req_ready_q, 1'b1);
      repeat (3) @(posedge ref_clk);
      if (!pend_m && !ovf_m) begin
         if (mask_m) ip_m = 1'b1;
         else exp_irq++;
      end
      if (exp_wr) pend_m = 1'b1;
      else ovf_m = 1'b1;
   endtask
   // ==================================================
   // group responses, back to back; slot 7 carries another type
   task automatic resp_burst(input logic wide);
      logic [255:0] d;
      int i, j;
      for (i = 0; i < 8; i++) begin
         for (j = 0; j < 8; j++) d[j*32+:32] = $random(seed);
         if (i < 3) d[DSC_RC_LSB+:RC_W] = (i == 0) ? RC_SUCCESS : (i == 1) ? RC_INVALID : RC_FAILURE;
         d[11:9] = (i == 7 && wide) ? 3'b001 : TYPE_GRP_RESP[6:4];
         d[3:0] = (i == 7 && !wide) ? 4'h1 : TYPE_GRP_RESP[3:0];
         // in wide mode each group response is expected back with the fields of its own descriptor
         if (i != 7 && wide) exp_q.push_back({d[DSC_RID_LSB+:RID_W], d[DSC_PASID_ON_BIT],
            d[DSC_PASID_ON_BIT] ? d[DSC_PASID_LSB+:PASID_W] : 20'h0, d[DSC_GRP_LSB+:GRP_W], d[DSC_RC_LSB+:RC_W]});
         if (i != 7 && !wide) derr_exp++;
         @(posedge ref_clk);
         iq_valid <= 1'b1;
         iq_desc <= d;
      end
      @(posedge ref_clk);
      iq_valid <= 1'b0;
      iq_desc <= ~d;
      repeat (3) @(posedge ref_clk);
   endtask
   // ==================================================
   // monitor: values sampled at the edge belong to the cycle just ended
   always @(posedge ref_clk) begin
      if (resetn === 1'b1 && irq_q === 1'b1) begin
         irq_cnt++;
         chk(irq_addr_q, ev_addr);
         chk(irq_data_q, ev_data);
         chk(dsc_wr_valid_q, 1'b0);
      end
      if (resetn === 1'b1 && resp_valid_q === 1'b1) begin
         resp_cnt++;
         if (exp_q.size() > 0) chk({resp_rid_q, resp_pasid_on_q, resp_pasid_q, resp_grp_q, resp_code_q},
            exp_q.pop_front());
      end
      if (resetn === 1'b1 && desc_err_q === 1'b1) derr_cnt++;
   end
   always #20 ref_clk = ~ref_clk;
   initial begin
      #2000000;
      bail();
   end
   initial begin
      tail_m = IDX_RST;
      repeat (16) @(posedge ref_clk);
      resetn <= 1'b1;
      repeat (2) @(posedge ref_clk);
      regs_chk();
      rchk(ADDR_IQCFG, 32'h0000_0001);
      rchk(8'hfc, 32'h0000_0000);
      ev_addr = $random(seed);
      ev_data = $random(seed);
      wr(ADDR_EVADDR, ev_addr);
      wr(ADDR_EVDATA, ev_data);
      rchk(ADDR_EVADDR, ev_addr);
      rchk(ADDR_EVDATA, ev_data);
      wr(ADDR_TAIL, 32'h0000_000f);
      wr(ADDR_EVCTL, 32'h0000_0000);
      send(1'b1);
      regs_chk();
      vis_delay <= 4'h5;
      send(1'b1);
      regs_chk();
      wr(ADDR_STATUS, 32'h0000_0003);
      wr(ADDR_EVCTL, 32'h8000_0000);
      send(1'b1);
      regs_chk();
      wr(ADDR_EVCTL, 32'h0000_0000);
      regs_chk();
      wr(ADDR_STATUS, 32'h0000_0003);
      wr(ADDR_EVCTL, 32'h8000_0000);
      send(1'b1);
      wr(ADDR_STATUS, 32'h0000_0001);
      wr(ADDR_EVCTL, 32'h0000_0000);
      regs_chk();
      // head two ahead of tail still has room; after that write the queue is full
      h = tail_m + 4'h2;
      wr(ADDR_HEAD, {28'h0, h});
      rchk(ADDR_HEAD, {28'h0, h});
      send(1'b1);
      wr(ADDR_STATUS, 32'h0000_0003);
      send(1'b0);
      regs_chk();
      send(1'b0);
      regs_chk();
      wr(ADDR_IQCFG, 32'h0000_0000);
      resp_burst(1'b0);
      wr(ADDR_IQCFG, 32'h0000_0001);
      resp_burst(1'b1);
      chk(derr_cnt, derr_exp);
      chk(resp_cnt, 7);
      chk(exp_q.size(), 0);
      end_of_test();
   end
endmodule
